// ==== rtl/listen_seq_pkg.sv ====
package listen_seq_pkg;

	// ------------------------------------------------------------------
	// Clock and timebase
	// ------------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 20;
	localparam int          TICK_PERIOD_NS = 1000;                          // Timer unit is one microsecond
	localparam int          TICK_CYCLES   = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]  TICK_LAST     = 8'(TICK_CYCLES - 1);

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [4:0]  OFS_CONTROL    = 5'h00;
	localparam logic [4:0]  OFS_SEQ_CONFIG = 5'h04;
	localparam logic [4:0]  OFS_TIMER_A    = 5'h08;
	localparam logic [4:0]  OFS_TIMER_B    = 5'h0C;
	localparam logic [4:0]  OFS_RX_TIMEOUT = 5'h10;
	localparam logic [4:0]  OFS_PIN_MAP    = 5'h14;
	localparam logic [4:0]  OFS_STATUS     = 5'h18;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int          CTRL_START_BIT  = 0;
	localparam int          CTRL_STOP_BIT   = 1;
	localparam int          CFG_IDLE_PWR    = 0;
	localparam int          CFG_START_LO    = 1;
	localparam int          CFG_LP_TARGET   = 3;
	localparam int          CFG_IDLE_EXIT   = 4;
	localparam int          CFG_RX_EXIT_LO  = 5;
	localparam int          CFG_TMO_EXIT_LO = 8;
	localparam int          MAP_ROUTE_BIT   = 10;
	localparam int          ST_PREAMBLE_BIT = 8;
	localparam int          ST_SYNC_BIT     = 9;
	localparam int          ST_PAYLOAD_BIT  = 10;
	localparam int          ST_CRC_BIT      = 11;
	localparam int          ST_FIFO_THR_BIT = 12;
	localparam int          ST_FIFO_DRN_BIT = 13;

	// ------------------------------------------------------------------
	// Reset values and field codes
	// ------------------------------------------------------------------
	localparam logic [9:0]  SEQ_CONFIG_RESET = 10'h000;
	localparam logic [15:0] TIMER_RESET      = 16'h0000;
	localparam logic [10:0] PIN_MAP_RESET    = 11'h000;
	localparam logic [1:0]  START_TO_LOW_POWER = 2'h0;
	localparam logic [2:0]  RX_EXIT_PREAMBLE = 3'h6;
	localparam logic [2:0]  RX_EXIT_SYNC     = 3'h5;
	localparam logic [2:0]  RX_EXIT_PAYLOAD  = 3'h4;
	localparam logic [1:0]  TMO_TO_LOW_POWER = 2'h2;
	localparam logic [1:0]  PIN_CODE_00 = 2'h0;
	localparam logic [1:0]  PIN_CODE_01 = 2'h1;
	localparam logic [1:0]  PIN_CODE_11 = 2'h3;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		RADIO_SLEEP   = 2'h0,
		RADIO_STANDBY = 2'h1,
		RADIO_RX      = 2'h3
	} radio_mode_t;

	typedef enum logic [2:0] {
		SEQ_OFF      = 3'h0,
		SEQ_IDLE     = 3'h1,
		SEQ_RX       = 3'h3,
		SEQ_RX_WAIT  = 3'h2,
		SEQ_HANDOFF  = 3'h6,
		SEQ_LOW_REST = 3'h7
	} seq_state_t;

endpackage : listen_seq_pkg

// ==== rtl/tick_down_counter.sv ====
`timescale 1ns/1ps
module tick_down_counter (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        ce,
	// Control
	input  wire logic        load,
	input  wire logic [15:0] load_value,
	input  wire logic        tick,
	// Result
	output logic             done
);

	logic [15:0] count;
	logic        running;

	// ------------------------------------------------------------------
	// Down counter, one pulse on expiry
	// ------------------------------------------------------------------
	// Load wins over an expiry in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count   <= 16'h0000;
			running <= 1'b0;
			done    <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (load) begin
				count   <= load_value;
				running <= 1'b1;
			end else if (running && tick) begin
				if (count <= 16'h0001) begin
					running <= 1'b0;
					done    <= 1'b1;
				end else begin
					count <= count - 16'h0001;
				end
			end
		end
	end

endmodule : tick_down_counter

// ==== rtl/listen_mode_top_sequencer.sv ====
`timescale 1ns/1ps
// Operation
// - Listen mode sleeps with only RC oscillator, periodically enabling receive.
// - A received packet raises an interrupt request toward the host.
// - Wake event selectable: preamble found, sync match, or payload done.
// - Any wake event stops sequencer, radio stays receiving until host acts.
// - Idle wakes every timer A plus B, receives for timer B.
// - Preamble found event can be routed to event pin four.
// - Timer B bounds receive time per cycle while no preamble.
// - Timer A plus timer B sets the interval between search starts.
// - Sync wake first polls preamble, then waits for sync match.
// - Sync wake receives only for rx timeout, low power for rest.
// - Preamble before rx timeout keeps receive, waiting for sync match.
// - No sync by timer B end: receive off, polling resumes alone.
// - Sync match fires event, stops sequencer, radio stays receiving.
module listen_mode_top_sequencer (
	// Clock, reset and clock enable
	input  wire logic                      clk,
	input  wire logic                      reset,
	input  wire logic                      ce,
	// Avalon-MM slave
	input  wire logic [4:0]                address,
	input  wire logic                      read,
	input  wire logic                      write,
	input  wire logic [31:0]               writedata,
	input  wire logic [3:0]                byteenable,
	output logic [31:0]                    readdata,
	output logic                           waitrequest,
	// Receive chain events
	input  wire logic                      preamble_found_event,
	input  wire logic                      sync_match_event,
	input  wire logic                      payload_done_event,
	input  wire logic                      crc_pass_event,
	input  wire logic                      fifo_threshold_flag,
	input  wire logic                      fifo_drained_flag,
	// Radio control and event pins
	output listen_seq_pkg::radio_mode_t    radio_mode,
	output listen_seq_pkg::seq_state_t     seq_state,
	output logic [3:0]                     event_pins_low,
	output logic                           event_pin_four
);
	import listen_seq_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [9:0]   seq_config;
	logic [15:0]  cycle_timer_a;
	logic [15:0]  cycle_timer_b;
	logic [15:0]  rx_window_timeout;
	logic [10:0]  pin_map;
	logic [3:0]   event_flags;
	logic         ack;
	logic [7:0]   prescale;
	logic         tick;
	logic         start_cmd;
	logic         stop_cmd;
	logic         bus_write;
	logic         phase_load;
	logic [15:0]  phase_value;
	logic         phase_done;
	logic         window_load;
	logic         window_done;
	logic         exit_event;
	logic         timeout_mode;
	seq_state_t   next_seq_state;
	radio_mode_t  low_power_mode;
	logic         idle_power_select;
	logic [1:0]   start_transition_sel;
	logic         low_power_target_sel;
	logic         idle_exit_sel;
	logic [2:0]   receive_exit_sel;
	logic [1:0]   timeout_exit_sel;
	logic         preamble_pin_route_sel;

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_value, input logic [31:0] new_value,
			input logic [3:0] lanes);
		logic [31:0] result;
		result = old_value;
		for (int i = 0; i < 4; i++) begin
			if (lanes[i]) begin
				result[i*8 +: 8] = new_value[i*8 +: 8];
			end
		end
		return result;
	endfunction : merge_bytes

	// Event source for one pin from its two-bit mapping code
	function automatic logic pin_source(input logic [1:0] code, input logic code00_src, input logic code01_src,
			input logic code11_src);
		logic result;
		result = 1'b0;
		if (code == PIN_CODE_00) begin
			result = code00_src;
		end else if (code == PIN_CODE_01) begin
			result = code01_src;
		end else if (code == PIN_CODE_11) begin
			result = code11_src;
		end
		return result;
	endfunction : pin_source

	// ------------------------------------------------------------------
	// Configuration fields
	// ------------------------------------------------------------------
	assign idle_power_select      = seq_config[CFG_IDLE_PWR];
	assign start_transition_sel   = seq_config[CFG_START_LO +: 2];
	assign low_power_target_sel   = seq_config[CFG_LP_TARGET];
	assign idle_exit_sel          = seq_config[CFG_IDLE_EXIT];
	assign receive_exit_sel       = seq_config[CFG_RX_EXIT_LO +: 3];
	assign timeout_exit_sel       = seq_config[CFG_TMO_EXIT_LO +: 2];
	assign preamble_pin_route_sel = pin_map[MAP_ROUTE_BIT];
	assign low_power_mode         = idle_power_select ? RADIO_SLEEP : RADIO_STANDBY;

	// ------------------------------------------------------------------
	// Avalon-MM handshake
	// ------------------------------------------------------------------
	// Every access is answered one cycle after it is presented
	assign waitrequest = (read || write) && !ack;
	assign bus_write   = write && !ack;
	assign start_cmd   = bus_write && (address == OFS_CONTROL) && byteenable[0] && writedata[CTRL_START_BIT];
	assign stop_cmd    = bus_write && (address == OFS_CONTROL) && byteenable[0] && writedata[CTRL_STOP_BIT];

	// Acknowledge flop
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ack <= 1'b0;
		end else if (ce) begin
			ack <= (read || write) && !ack;
		end
	end

	// Configuration register writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			seq_config        <= SEQ_CONFIG_RESET;
			cycle_timer_a     <= TIMER_RESET;
			cycle_timer_b     <= TIMER_RESET;
			rx_window_timeout <= TIMER_RESET;
			pin_map           <= PIN_MAP_RESET;
		end else if (ce && bus_write) begin
			unique case ({address[4:2], 2'b00})
				OFS_SEQ_CONFIG: seq_config <= 10'(merge_bytes(32'(seq_config), writedata, byteenable));
				OFS_TIMER_A:    cycle_timer_a <= 16'(merge_bytes(32'(cycle_timer_a), writedata, byteenable));
				OFS_TIMER_B:    cycle_timer_b <= 16'(merge_bytes(32'(cycle_timer_b), writedata, byteenable));
				OFS_RX_TIMEOUT: rx_window_timeout <= 16'(merge_bytes(32'(rx_window_timeout), writedata, byteenable));
				OFS_PIN_MAP:    pin_map <= 11'(merge_bytes(32'(pin_map), writedata, byteenable));
				default: begin
				end
			endcase
		end
	end

	// Read data, registered; unmapped offsets read zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			readdata <= 32'h00000000;
		end else if (ce && read && !ack) begin
			unique case ({address[4:2], 2'b00})
				OFS_SEQ_CONFIG: readdata <= 32'(seq_config);
				OFS_TIMER_A:    readdata <= 32'(cycle_timer_a);
				OFS_TIMER_B:    readdata <= 32'(cycle_timer_b);
				OFS_RX_TIMEOUT: readdata <= 32'(rx_window_timeout);
				OFS_PIN_MAP:    readdata <= 32'(pin_map);
				OFS_STATUS:     readdata <= {18'h00000, fifo_drained_flag, fifo_threshold_flag, event_flags,
					5'h00, seq_state};
				default:        readdata <= 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Sticky event flags
	// ------------------------------------------------------------------
	// Write one to clear; a new event in the clearing cycle wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			event_flags <= 4'h0;
		end else if (ce) begin
			event_flags <= (event_flags & ~((bus_write && (address == OFS_STATUS) && byteenable[1]) ?
				writedata[ST_PREAMBLE_BIT +: 4] : 4'h0))
				| {crc_pass_event, payload_done_event, sync_match_event, preamble_found_event};
		end
	end

	// ------------------------------------------------------------------
	// Event pins
	// ------------------------------------------------------------------
	// Event-sourced pins show the held flags so a one-cycle event is not missed by the host; fifo pins show the live levels
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			event_pins_low <= 4'h0;
			event_pin_four <= 1'b0;
		end else if (ce) begin
			event_pins_low[0] <= pin_source(pin_map[1:0], event_flags[2], event_flags[3], 1'b0);
			event_pins_low[1] <= pin_source(pin_map[3:2], fifo_threshold_flag, 1'b0, 1'b0);
			event_pins_low[2] <= pin_source(pin_map[5:4], 1'b0, 1'b0, event_flags[1]);
			event_pins_low[3] <= pin_source(pin_map[7:6], fifo_drained_flag, 1'b0, 1'b0);
			event_pin_four    <= pin_source(pin_map[9:8], 1'b0, 1'b0,
				preamble_pin_route_sel && event_flags[0]);
		end
	end

	// ------------------------------------------------------------------
	// Timebase and timers
	// ------------------------------------------------------------------
	// Microsecond tick prescaler
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prescale <= 8'h00;
			tick     <= 1'b0;
		end else if (ce) begin
			tick     <= (prescale == TICK_LAST);
			prescale <= (prescale == TICK_LAST) ? 8'h00 : prescale + 8'h01;
		end
	end

	// Phase timer runs timer A in idle, then timer B from the receive start
	tick_down_counter phase_timer (
		.clk        (clk),
		.reset      (reset),
		.ce         (ce),
		.load       (phase_load),
		.load_value (phase_value),
		.tick       (tick),
		.done       (phase_done)
	);

	// Receive window timer for the timeout-bounded modes
	tick_down_counter window_timer (
		.clk        (clk),
		.reset      (reset),
		.ce         (ce),
		.load       (window_load),
		.load_value (rx_window_timeout),
		.tick       (tick),
		.done       (window_done)
	);

	// ------------------------------------------------------------------
	// Sequencer state machine
	// ------------------------------------------------------------------
	// Selected wake condition and whether the rx timeout applies
	always_comb begin
		exit_event   = 1'b0;
		timeout_mode = 1'b0;
		unique case (receive_exit_sel)
			RX_EXIT_PREAMBLE: exit_event = preamble_found_event;
			RX_EXIT_SYNC: begin
				exit_event   = sync_match_event;
				timeout_mode = (rx_window_timeout != 16'h0000);
			end
			RX_EXIT_PAYLOAD: begin
				exit_event   = payload_done_event;
				timeout_mode = (rx_window_timeout != 16'h0000);
			end
			default: exit_event = 1'b0;
		endcase
	end

	// Next state and timer loads
	always_comb begin
		next_seq_state = seq_state;
		phase_load     = 1'b0;
		phase_value    = cycle_timer_a;
		window_load    = 1'b0;
		if (stop_cmd) begin
			next_seq_state = SEQ_OFF;
		end else if (start_cmd && (start_transition_sel == START_TO_LOW_POWER)) begin
			next_seq_state = low_power_target_sel ? SEQ_IDLE : SEQ_OFF;
			phase_load     = low_power_target_sel;
		end else begin
			unique case (seq_state)
				SEQ_OFF, SEQ_HANDOFF: next_seq_state = seq_state;
				SEQ_IDLE: begin
					if (phase_done) begin
						phase_load = 1'b1;
						if (idle_exit_sel) begin
							next_seq_state = SEQ_RX;
							phase_value    = cycle_timer_b;
							window_load    = timeout_mode;
						end
					end
				end
				SEQ_RX: begin
					if (exit_event) begin
						next_seq_state = SEQ_HANDOFF;
					end else if (phase_done) begin
						next_seq_state = SEQ_IDLE;
						phase_load     = 1'b1;
					end else if (timeout_mode && preamble_found_event) begin
						next_seq_state = SEQ_RX_WAIT;
					end else if (timeout_mode && window_done) begin
						next_seq_state = (timeout_exit_sel == TMO_TO_LOW_POWER) ? SEQ_LOW_REST : SEQ_OFF;
					end
				end
				SEQ_RX_WAIT: begin
					if (exit_event) begin
						next_seq_state = SEQ_HANDOFF;
					end else if (phase_done) begin
						next_seq_state = SEQ_IDLE;
						phase_load     = 1'b1;
					end
				end
				SEQ_LOW_REST: begin
					if (phase_done) begin
						next_seq_state = SEQ_IDLE;
						phase_load     = 1'b1;
					end
				end
				default: next_seq_state = SEQ_OFF;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			seq_state <= SEQ_OFF;
		end else if (ce) begin
			seq_state <= next_seq_state;
		end
	end

	// Radio mode follows the next state; handoff keeps receiving until the host acts
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			radio_mode <= RADIO_SLEEP;
		end else if (ce) begin
			unique case (next_seq_state)
				SEQ_RX, SEQ_RX_WAIT, SEQ_HANDOFF: radio_mode <= RADIO_RX;
				SEQ_IDLE, SEQ_LOW_REST:           radio_mode <= low_power_mode;
				default:                          radio_mode <= (seq_state == SEQ_HANDOFF && !stop_cmd) ?
					RADIO_RX : low_power_mode;
			endcase
		end
	end

endmodule : listen_mode_top_sequencer

// ==== verification/listen_seq_asserts.sv ====
`timescale 1ns/1ps
module listen_seq_asserts (
	// Clock and reset
	input wire logic                        clk,
	input wire logic                        reset,
	input wire logic                        ce,
	// Register bus
	input wire logic                        read,
	input wire logic                        write,
	input wire logic [31:0]                 readdata,
	input wire logic                        waitrequest,
	// Receive events
	input wire logic                        preamble_found_event,
	input wire logic                        sync_match_event,
	input wire logic                        payload_done_event,
	// Radio and pins
	input wire listen_seq_pkg::radio_mode_t radio_mode,
	input wire listen_seq_pkg::seq_state_t  seq_state,
	input wire logic                        event_pin_four
);
	import listen_seq_pkg::*;

	// ------------------------------------------------------------------
	// Timing and state steps
	// ------------------------------------------------------------------
	localparam int RX_MAX = 260;                 // Longest bench timer B plus one tick and ten cycles
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_rx_entry;
		seq_state == SEQ_RX && $past(seq_state) == SEQ_IDLE;
	endsequence
	sequence s_handoff_entry;
		seq_state == SEQ_HANDOFF && $past(seq_state) != SEQ_HANDOFF;
	endsequence
	sequence s_wait_entry;
		seq_state == SEQ_RX_WAIT && $past(seq_state) != SEQ_RX_WAIT;
	endsequence

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_bus_one_wait: assert property ((read || write) && waitrequest && ce |=> !waitrequest)
		else $error("bus answer not after one wait cycle");
	a_rdata_holds: assert property (!(read && waitrequest) |=> $stable(readdata))
		else $error("read data changed without a read");
	a_idle_low_power: assert property (seq_state inside {SEQ_IDLE, SEQ_LOW_REST} |->
		radio_mode != RADIO_RX)
		else $error("receiver on while resting");
	a_window_receives: assert property (seq_state inside {SEQ_RX, SEQ_RX_WAIT} |-> radio_mode == RADIO_RX)
		else $error("receiver off inside window");
	a_handoff_receives: assert property (seq_state == SEQ_HANDOFF |-> radio_mode == RADIO_RX)
		else $error("receiver off after handoff");
	a_handoff_cause: assert property (s_handoff_entry |-> $past(seq_state) inside {SEQ_RX, SEQ_RX_WAIT}
		&& ($past(preamble_found_event) || $past(sync_match_event) || $past(payload_done_event)))
		else $error("handoff without a wake event");
	a_wait_cause: assert property (s_wait_entry |->
		$past(seq_state) == SEQ_RX && $past(preamble_found_event))
		else $error("wait for sync without preamble");
	a_rx_from_idle: assert property (seq_state == SEQ_RX && $past(seq_state) != SEQ_RX |->
		$past(seq_state) == SEQ_IDLE)
		else $error("receive window not opened from idle");
	a_rx_bounded: assert property (s_rx_entry |-> ##[1:RX_MAX] seq_state != SEQ_RX)
		else $error("receive window too long");
	a_pin_four_cause: assert property ($rose(event_pin_four) |-> $past(preamble_found_event, 2))
		else $error("pin four rose without preamble");
endmodule : listen_seq_asserts

bind listen_mode_top_sequencer listen_seq_asserts i_chk (.clk, .reset, .ce, .read, .write, .readdata,
	.waitrequest, .preamble_found_event, .sync_match_event, .payload_done_event, .radio_mode, .seq_state,
	.event_pin_four);

// ==== verification/rx_chain_model.sv ====
`timescale 1ns/1ps
module rx_chain_model (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// Radio state and bench control
	input  wire listen_seq_pkg::radio_mode_t radio_mode,
	input  wire logic [2:0]                  mask,
	input  wire logic [7:0]                  pre_delay,
	// Receive events
	output logic                             preamble_found_event,
	output logic                             sync_match_event,
	output logic                             payload_done_event,
	output logic                             crc_pass_event,
	output logic                             fifo_threshold_flag,
	output logic                             fifo_drained_flag
);
	import listen_seq_pkg::*;
	logic [9:0] rx_cycles;
	logic [9:0] fire_at;
	logic [7:0] noise;
	logic       on_air;

	assign fire_at = {2'h0, pre_delay};
	assign on_air  = radio_mode == RADIO_RX;

	// Cycles spent receiving since the window opened
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rx_cycles <= 10'h000;
		else if (!on_air)
			rx_cycles <= 10'h000;
		else if (rx_cycles != 10'h3FF)
			rx_cycles <= rx_cycles + 10'h001;
	end

	// Detections fire once per window and only while receiving
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			preamble_found_event <= 1'b0;
			sync_match_event     <= 1'b0;
			payload_done_event   <= 1'b0;
			crc_pass_event       <= 1'b0;
		end else begin
			preamble_found_event <= on_air && mask[0] && rx_cycles == fire_at;
			sync_match_event     <= on_air && mask[1] && rx_cycles == fire_at + 10'h014;
			payload_done_event   <= on_air && mask[2] && rx_cycles == fire_at + 10'h028;
			crc_pass_event       <= on_air && mask[2] && rx_cycles == fire_at + 10'h028;
		end
	end

	// Fifo levels wander so the live status bits move
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			noise <= 8'hA5;
		else
			noise <= {noise[6:0], noise[7] ^ noise[5] ^ noise[4] ^ noise[3]};
	end
	assign fifo_threshold_flag = noise[0];
	assign fifo_drained_flag   = noise[7];
endmodule : rx_chain_model

// ==== verification/listen_mode_top_sequencer_tb.sv ====
`timescale 1ns/1ps
module listen_mode_top_sequencer_tb;
	import listen_seq_pkg::*;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic        clk, reset, read, write, waitrequest;
	logic [4:0]  address;
	logic [31:0] writedata, readdata, rd, rnd;
	logic        pre, syn, pay, crc, fthr, fdrn, pin4;
	logic [3:0]  pins;
	logic [2:0]  mask;
	logic [7:0]  pre_delay;
	radio_mode_t radio_mode;
	seq_state_t  seq_state;
	int          num_errors, tests_run, cycles, n, n2, n3, a_us;
	logic [2:0]  exits [3] = '{RX_EXIT_PREAMBLE, RX_EXIT_SYNC, RX_EXIT_PAYLOAD};
	logic [4:0]  pin_exp [3] = '{5'h01, 5'h09, 5'h0B};

	listen_mode_top_sequencer i_dut (
		.clk(clk), .reset(reset), .ce(1'b1), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
		.preamble_found_event(pre), .sync_match_event(syn), .payload_done_event(pay), .crc_pass_event(crc),
		.fifo_threshold_flag(fthr), .fifo_drained_flag(fdrn), .radio_mode(radio_mode), .seq_state(seq_state),
		.event_pins_low(pins), .event_pin_four(pin4));
	rx_chain_model i_chain (
		.clk(clk), .reset(reset), .radio_mode(radio_mode), .mask(mask), .pre_delay(pre_delay),
		.preamble_found_event(pre), .sync_match_event(syn), .payload_done_event(pay), .crc_pass_event(crc),
		.fifo_threshold_flag(fthr), .fifo_drained_flag(fdrn));

	// Clock and hang limit
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			close_out();
		end
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] cfg_word(input logic [2:0] ex);
		return {22'h0, TMO_TO_LOW_POWER, ex, 1'b1, 1'b1, START_TO_LOW_POWER, 1'b1};
	endfunction : cfg_word

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task chk_near(input int got, input int exp, input int tol);
		tests_run++;
		if (got > exp + tol || got < exp - tol) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_near

	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		address   <= a;
		writedata <= d;
		write     <= wr;
		read      <= !wr;
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		write <= 1'b0;
		read  <= 1'b0;
	endtask : bus

	task wait_state(input seq_state_t s);
		n = 0;
		while (seq_state !== s) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_state

	task setup(input logic [2:0] ex, input int a, input int b, input int t);
		bus(1'b1, OFS_SEQ_CONFIG, cfg_word(ex));
		bus(1'b1, OFS_TIMER_A, 32'(a));
		bus(1'b1, OFS_TIMER_B, 32'(b));
		bus(1'b1, OFS_RX_TIMEOUT, 32'(t));
		bus(1'b1, OFS_CONTROL, 32'h0000_0001);
	endtask : setup

	task close_out;
		$display("errors %0d compares %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{reset, read, write, address, writedata, mask} = {1'b1, 42'h0};
		pre_delay = 8'h08;
		num_errors = 0;
		tests_run = 0;
		cycles = 0;
		void'($urandom(32'hE8EA7771));
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		// Reset values, read back, unmapped and write-only places
		bus(1'b0, OFS_SEQ_CONFIG, 32'h0);
		chk(rd, 32'(SEQ_CONFIG_RESET));
		rnd = $urandom;
		bus(1'b1, OFS_TIMER_B, rnd);
		bus(1'b0, OFS_TIMER_B, 32'h0);
		chk(rd, rnd & 32'h0000_FFFF);
		bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
		bus(1'b0, 5'h1C, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, OFS_CONTROL, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, OFS_PIN_MAP, 32'h0000_0731);
		bus(1'b0, OFS_PIN_MAP, 32'h0);
		chk(rd, 32'h0000_0731);
		// Quiet air: window length and polling period
		a_us = 1 + $urandom_range(2);
		setup(RX_EXIT_PREAMBLE, a_us, 3, 0);
		wait_state(SEQ_RX);
		wait_state(SEQ_IDLE);
		n2 = n;
		chk_near(n2, 3 * TICK_CYCLES, TICK_CYCLES);
		wait_state(SEQ_RX);
		chk_near(n + n2, (a_us + 3) * TICK_CYCLES, 2 * TICK_CYCLES);
		bus(1'b1, OFS_CONTROL, 32'h0000_0002);
		chk(32'(seq_state), 32'(SEQ_OFF));
		// Each wake condition ends polling on its own event
		mask = 3'b111;
		for (int i = 0; i < 3; i++) begin
			pre_delay = 8'($urandom_range(40));
			setup(exits[i], 1, 4, 0);
			wait_state(SEQ_RX);
			wait_state(SEQ_HANDOFF);
			chk_near(n, int'(pre_delay) + 20 * i + 2, 3);
			repeat (3) @(negedge clk);
			chk(32'({pins, pin4} & 5'h0B), 32'(pin_exp[i]));
			repeat (300) @(negedge clk);
			chk(32'(seq_state), 32'(SEQ_HANDOFF));
			chk(32'(radio_mode), 32'(RADIO_RX));
			bus(1'b0, OFS_STATUS, 32'h0);
			chk(rd & 32'h0000_0107, 32'h0000_0106);
			bus(1'b1, OFS_STATUS, 32'h0000_0F00);
			bus(1'b1, OFS_CONTROL, 32'h0000_0002);
		end
		// Sync wake: short windows, then preamble without sync
		mask = 3'b000;
		setup(RX_EXIT_SYNC, 2, 4, 1);
		wait_state(SEQ_RX);
		wait_state(SEQ_LOW_REST);
		n3 = n;
		chk_near(n3, TICK_CYCLES, TICK_CYCLES);
		wait_state(SEQ_IDLE);
		n2 = n;
		pre_delay = 8'h0A;
		mask = 3'b001;
		wait_state(SEQ_RX);
		chk_near(n + n2 + n3, 6 * TICK_CYCLES, 2 * TICK_CYCLES);
		wait_state(SEQ_RX_WAIT);
		mask = 3'b000;
		wait_state(SEQ_IDLE);
		chk_near(n, 4 * TICK_CYCLES - 12, TICK_CYCLES);
		wait_state(SEQ_RX);
		chk_near(n, 2 * TICK_CYCLES, TICK_CYCLES);
		bus(1'b1, OFS_CONTROL, 32'h0000_0002);
		chk(32'(seq_state), 32'(SEQ_OFF));
		close_out();
	end
endmodule : listen_mode_top_sequencer_tb
